/* File: dv/dram_refresh_powerdown_tb.sv */
// Self-checking bench for the refresh and power-down sequencer.
// Assumes drpd_ctrl and the memory model share one 25 MHz clock.
`timescale 1ns/1ps
`include "drpd_map.svh"
module dram_refresh_powerdown_tb;
    localparam int LIMIT = 12000;
    localparam int AVG_REFRESH_INTERVAL = `DRPD_AVG_REFRESH_INTERVAL_CYC;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    drpd_pkg::drpd_user_type user = '0;
    drpd_pkg::drpd_pins_type pins;
    drpd_pkg::drpd_status_type status;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    int n;
    int memErrs;
    logic memSr;
    logic memPd;
    logic [6:0] fl;
    assign fl = {status.clkStopOk, status.refUrgent, status.cmdTaken, pins.cke,
        status.inSelfRefresh, status.inPowerDown, status.refAck};

    drpd_ctrl dut_u (.clk(clk), .rst_n(rst_n), .user(user), .pins(pins), .status(status));
    drpd_mem_model mem_u (.clk(clk), .pins(pins), .allClosed(user.banksIdle), .keepBit(user.dllKeep),
        .errs(memErrs), .inSr(memSr), .inPd(memPd));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bounded wait on one status flag or the clock enable pin; a miss counts as a mismatch
    task automatic waitFor(input int k, input logic v, input int lim);
        n = 0;
        while (fl[k] !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        check(16'(fl[k] === v), 16'h0001);
    endtask

    task automatic idle(input int c);
        repeat (c) @(negedge clk);
    endtask

    task automatic drain();
        n = 0;
        while (status.debt !== 5'h00 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check({11'h000, status.debt}, 16'h0000);
    endtask

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            wrap_up();
        end
    end

    task automatic t_refresh();
        user.refReq = 1'b1;
        repeat (8) begin
            @(negedge clk);
            check(16'(status.refAck), 16'h0000);
        end
        user.banksIdle = 1'b1;
        waitFor(0, 1'b1, 10);
        check(16'(pins.cmd), 16'h0001);
        user.refReq = 1'b0;
        repeat (3) begin
            @(negedge clk);
            check(16'(pins.cmd), 16'h0007);
        end
        check({11'h000, status.debt}, 16'h0000);
        user.cmd = 4'h4;
        user.cmdValid = 1'b1;
        waitFor(4, 1'b1, 10);
        check(16'(pins.cmd), 16'h0004);
        user.cmdValid = 1'b0;
        $display("refresh test done");
    endtask

    task automatic t_postpone();
        // Start right after a regular refresh so the gap is measured from it
        waitFor(0, 1'b1, 2 * AVG_REFRESH_INTERVAL + 20);
        user.cmd = 4'h7;
        user.cmdValid = 1'b1;
        waitFor(5, 1'b1, 9 * AVG_REFRESH_INTERVAL);
        check({11'h000, status.debt}, 16'h0008);
        waitFor(0, 1'b1, 10);
        user.cmdValid = 1'b0;
        drain();
        $display("postpone test done");
    endtask

    task automatic t_pd_slow();
        user.odtReq = 1'b1;
        user.busyOp = 1'b1;
        user.pdEnterReq = 1'b1;
        repeat (20) begin
            @(negedge clk);
            check({14'h0000, pins.cke, status.inPowerDown}, 16'h0002);
        end
        user.busyOp = 1'b0;
        waitFor(1, 1'b1, 10);
        user.pdEnterReq = 1'b0;
        idle(2);
        check({12'h000, pins.cmd}, 16'h000F);
        check({13'h0000, pins.cke, pins.termination_control, memPd}, 16'h0001);
        waitFor(1, 1'b0, 9 * AVG_REFRESH_INTERVAL);
        check(16'(pins.cke), 16'h0001);
        user.odtReq = 1'b0;
        drain();
        $display("slow power-down test done");
    endtask

    task automatic t_pd_fast();
        user.dllKeep = 1'b1;
        user.banksIdle = 1'b0;
        user.odtReq = 1'b1;
        idle(2);
        user.pdEnterReq = 1'b1;
        waitFor(1, 1'b1, 10);
        user.pdEnterReq = 1'b0;
        idle(3);
        check(16'(pins.termination_control), 16'h0001);
        user.pdExitReq = 1'b1;
        waitFor(1, 1'b0, 10);
        user.pdExitReq = 1'b0;
        check(16'(pins.cke), 16'h0001);
        user.odtReq = 1'b0;
        user.banksIdle = 1'b1;
        $display("fast power-down test done");
    endtask

    task automatic t_pd_reset();
        idle(6);
        user.pdEnterReq = 1'b1;
        waitFor(1, 1'b1, 10);
        user.pdEnterReq = 1'b0;
        user.dramRst = 1'b1;
        idle(2);
        check({10'h000, pins.cmd, pins.cke, pins.resetN}, 16'h003C);
        check({10'h000, status.inPowerDown, status.debt}, 16'h0000);
        user.dramRst = 1'b0;
        waitFor(3, 1'b1, 20);
        idle(3);
        $display("reset in power-down test done");
    endtask

    task automatic t_pull();
        user.refReq = 1'b1;
        idle(60);
        user.refReq = 1'b0;
        idle(5);
        // A tick may land after the last pull, leaving one short of the cap
        check(16'(status.debt === 5'h18 || status.debt === 5'h19), 16'h0001);
        $display("pull-in test done");
    endtask

    task automatic t_sr();
        int t0;
        user.odtReq = 1'b1;
        idle(3);
        user.srEnterReq = 1'b1;
        waitFor(2, 1'b1, 20);
        user.srEnterReq = 1'b0;
        check({14'h0000, pins.cke, pins.termination_control}, 16'h0000);
        waitFor(6, 1'b1, 10);
        check(16'(memSr), 16'h0001);
        idle(10);
        user.cmd = 4'h2;
        user.cmdNeedsDll = 1'b0;
        user.cmdValid = 1'b1;
        user.srExitReq = 1'b1;
        waitFor(3, 1'b1, 20);
        t0 = cycles;
        user.srExitReq = 1'b0;
        // A command that needs no DLL may follow the short exit delay
        waitFor(4, 1'b1, 20);
        check(16'(n >= `DRPD_TXS_CYC), 16'h0001);
        check({11'h000, status.dllReady, pins.cmd}, 16'h0002);
        user.cmd = 4'h4;
        user.cmdNeedsDll = 1'b1;
        idle(1);
        waitFor(4, 1'b1, 600);
        check(16'(cycles - t0 >= `DRPD_SR_EXIT_DLL_DELAY_CYC), 16'h0001);
        check({11'h000, status.dllReady, pins.cmd}, 16'h0014);
        user.cmdValid = 1'b0;
        idle(5);
        $display("self-refresh test done");
    endtask

    initial begin
        idle(6);
        check({9'h000, pins}, 16'h0078);
        rst_n = 1'b1;
        idle(4);
        check({9'h000, pins}, 16'h003D);
        t_refresh();
        t_postpone();
        t_pd_slow();
        t_pd_fast();
        t_pd_reset();
        t_pull();
        t_sr();
        check(16'(memErrs), 16'h0000);
        wrap_up();
    end
endmodule // dram_refresh_powerdown_tb

/* File: dv/drpd_mem_model.sv */
// Memory device model: decodes the command pins and counts protocol slips by the controller.
// Assumes one shared clock; bank state and the keep bit come from the bench.
`timescale 1ns/1ps
`include "drpd_map.svh"
module drpd_mem_model (
    input wire logic clk,
    input drpd_pkg::drpd_pins_type pins,
    input wire logic allClosed,
    input wire logic keepBit,
    output int errs,
    output logic inSr,
    output logic inPd
);
    logic ckeQ = 1'b0;
    logic dllOn = 1'b1;
    logic slow = 1'b0;
    int sinceRef = 999;
    int sinceWake = 999;
    int sincePdOut = 999;
    int gap = 0;
    int odtLow = 0;
    int pdLen = 0;
    logic quiet;
    assign quiet = (pins.cmd === `DRPD_CMD_NOP) || (pins.cmd[3] === 1'b1);
    // Reset pin is low from the first edge, so the reset branch clears the mode flags
    always @(posedge clk) begin
        sinceRef++;
        sinceWake++;
        sincePdOut++;
        gap++;
        if (pins.resetN !== 1'b1) begin
            inSr = 1'b0;
            inPd = 1'b0;
            dllOn = 1'b1;
            gap = 0;
        end else if (inSr) begin
            if (pins.cke === 1'b1) begin
                inSr = 1'b0;
                dllOn = 1'b1;
                sinceWake = 0;
                gap = 0;
                errs += int'(!quiet);
            end
        end else if (inPd) begin
            if (pins.cke === 1'b1) begin
                inPd = 1'b0;
                dllOn = 1'b1;
                sincePdOut = 0;
                errs += int'(!quiet);
            end
        end else if (ckeQ && pins.cke === 1'b0) begin
            if (pins.cmd === `DRPD_CMD_REF) begin
                inSr = 1'b1;
                dllOn = 1'b0;
                gap = 0;
                errs += int'(odtLow < `DRPD_ODT_OFF_CYC);
            end else begin
                inPd = 1'b1;
                slow = allClosed && !keepBit;
                dllOn = !slow;
                errs += int'(!quiet);
            end
        end else if (!quiet) begin
            errs += int'(sinceRef < `DRPD_REFRESH_CYCLE_TIME_CYC || sinceWake < `DRPD_TXS_CYC);
            if (pins.cmd === `DRPD_CMD_REF) begin
                sinceRef = 0;
                gap = 0;
            end
            // Reads and writes need the DLL; slow exit waits the longer delay
            // Byte masks ride with write data; no data path is modelled here
            if (pins.cmd[3:1] === 3'b010) begin
                errs += int'(sinceWake < 512 || !dllOn || (slow && sincePdOut < `DRPD_PD_EXIT_DLL_DELAY_CYC));
            end
        end
        errs += int'(sinceWake < 512 && pins.termination_control === 1'b1);
        if (gap > 9 * `DRPD_AVG_REFRESH_INTERVAL_CYC + 8) begin
            errs++;
            gap = 0;
        end
        pdLen = inPd ? pdLen + 1 : 0;
        errs += int'(pdLen > 9 * `DRPD_AVG_REFRESH_INTERVAL_CYC);
        odtLow = (pins.termination_control === 1'b0) ? odtLow + 1 : 0;
        ckeQ = pins.cke;
    end
endmodule // drpd_mem_model

/* File: src/drpd_ctrl.sv */
// Host-side refresh, self-refresh and power-down sequencer driving the memory command pins.
// The user side shares clk; the user owns bank state and tells us when banks are idle or busy.
`timescale 1ns/1ps
`include "drpd_map.svh"
module drpd_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input drpd_pkg::drpd_user_type user,
    output drpd_pkg::drpd_pins_type pins,
    output drpd_pkg::drpd_status_type status
);
    typedef struct packed {
        drpd_pkg::drpd_state_type st;
        logic signed [4:0] debt;
        logic [3:0] preCnt;
        logic slowExit;
        logic [9:0] lowCnt;
        drpd_pkg::drpd_pins_type pins;
        drpd_pkg::drpd_status_type stat;
    } drpd_regs_type;

    logic [1:0] rstSync;
    logic rstLocalN;
    drpd_regs_type q, d;
    logic tick, tickLoad, waitZero, load;
    logic [9:0] loadVal;
    logic prechOk, urgent, refGo, inc, userPass;

    // Reset enters asynchronously, releases through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstLocalN = rstSync[1];

    assign tickLoad = tick;
    drpd_timer u_tick (
        .clk(clk),
        .rstN(rstLocalN),
        .load(tickLoad),
        .loadVal(10'(`DRPD_AVG_REFRESH_INTERVAL_CYC - 1)),
        .zero(tick)
    );

    drpd_timer u_wait (
        .clk(clk),
        .rstN(rstLocalN),
        .load(load),
        .loadVal(loadVal),
        .zero(waitZero)
    );

    always_comb begin
        d = q;
        load = 1'b0;
        loadVal = 10'h000;
        refGo = 1'b0;
        userPass = 1'b0;
        d.pins.cmd = `DRPD_CMD_NOP;
        d.pins.resetN = 1'b1;
        d.stat.cmdTaken = 1'b0;
        d.stat.refAck = 1'b0;
        // Banks must sit idle a full precharge time before a refresh
        d.preCnt = !user.banksIdle ? 4'h0 : (q.preCnt < 4'(`DRPD_TRP_CYC) ? q.preCnt + 4'h1 : q.preCnt);
        prechOk = user.banksIdle && (q.preCnt >= 4'(`DRPD_TRP_CYC));
        urgent = (q.debt >= `DRPD_DEBT_MAX);
        unique case (q.st)
            drpd_pkg::IDLE: begin
                d.pins.cke = 1'b1;
                d.pins.termination_control = user.odtReq;
                if (urgent && prechOk) begin
                    refGo = 1'b1;
                end else if (user.srEnterReq && prechOk && q.debt <= `DRPD_DEBT_ZERO) begin
                    d.st = drpd_pkg::SR_PREP;
                    d.pins.termination_control = 1'b0;
                    load = 1'b1;
                    loadVal = 10'(`DRPD_ODT_OFF_CYC - 1);
                end else if (prechOk && ((q.debt > `DRPD_DEBT_ZERO && (!user.cmdValid || user.srEnterReq))
                             || (user.refReq && q.debt > `DRPD_DEBT_MIN))) begin
                    refGo = 1'b1;
                end else if (user.pdEnterReq && !user.busyOp && !urgent) begin
                    d.st = drpd_pkg::PD_ENTRY;
                    d.pins.cke = 1'b0;
                    d.slowExit = user.banksIdle && !user.dllKeep;
                    load = 1'b1;
                    loadVal = 10'(`DRPD_PD_ENTRY_CMD_DELAY_CYC - 1);
                end else if (user.cmdValid && !urgent) begin
                    userPass = 1'b1;
                end
                if (refGo) begin
                    d.pins.cmd = `DRPD_CMD_REF;
                    d.st = drpd_pkg::REF_WAIT;
                    d.stat.refAck = 1'b1;
                    load = 1'b1;
                    loadVal = 10'(`DRPD_REFRESH_CYCLE_TIME_CYC - 1);
                end
            end
            drpd_pkg::REF_WAIT: begin
                if (waitZero) begin
                    d.st = drpd_pkg::IDLE;
                end
            end
            drpd_pkg::SR_PREP: begin
                d.pins.termination_control = 1'b0;
                if (waitZero) begin
                    d.pins.cmd = `DRPD_CMD_REF;
                    d.pins.cke = 1'b0;
                    d.st = drpd_pkg::SR;
                    d.lowCnt = 10'h000;
                end
            end
            drpd_pkg::SR: begin
                // Clock enable stays low until the minimum stay and an exit request
                d.pins.cmd = `DRPD_CMD_DES;
                d.lowCnt = (q.lowCnt == 10'h3FF) ? q.lowCnt : q.lowCnt + 10'h001;
                d.stat.clkStopOk = (q.lowCnt >= 10'(`DRPD_SR_ENTRY_CLOCK_HOLD_CYC));
                if (user.srExitReq && q.lowCnt >= 10'(`DRPD_MIN_CLOCK_ENABLE_PULSE_CYC)) begin
                    d.st = drpd_pkg::SR_WAKE;
                    d.stat.clkStopOk = 1'b0;
                    load = 1'b1;
                    loadVal = 10'(`DRPD_SR_EXIT_CLOCK_SETUP_CYC - 1);
                end
            end
            drpd_pkg::SR_WAKE: begin
                // Clock must run stable for a while before clock enable rises
                d.pins.cmd = `DRPD_CMD_DES;
                if (waitZero) begin
                    d.pins.cmd = `DRPD_CMD_NOP;
                    d.pins.cke = 1'b1;
                    d.st = drpd_pkg::SR_EXIT;
                    load = 1'b1;
                    loadVal = 10'(`DRPD_TXS_CYC - 1);
                end
            end
            drpd_pkg::SR_EXIT: begin
                if (waitZero) begin
                    d.st = drpd_pkg::SR_DLL;
                    load = 1'b1;
                    loadVal = 10'(`DRPD_SR_EXIT_DLL_DELAY_CYC - `DRPD_TXS_CYC - 1);
                end
            end
            drpd_pkg::SR_DLL: begin
                // Only commands that run without a locked DLL; writes wait too
                userPass = user.cmdValid && !user.cmdNeedsDll && !waitZero;
                if (waitZero) begin
                    d.st = drpd_pkg::IDLE;
                end
            end
            drpd_pkg::PD_ENTRY: begin
                if (waitZero) begin
                    d.st = drpd_pkg::PD;
                    d.lowCnt = 10'h000;
                end
            end
            drpd_pkg::PD: begin
                d.pins.cmd = `DRPD_CMD_DES;
                d.lowCnt = (q.lowCnt == 10'h3FF) ? q.lowCnt : q.lowCnt + 10'h001;
                if (q.slowExit) begin
                    d.pins.termination_control = 1'b0;
                end
                // Full debt or a saturated stay counter ends power-down well inside nine intervals
                if ((user.pdExitReq || urgent || q.lowCnt == 10'h3FF) && q.lowCnt >= 10'(`DRPD_MIN_CLOCK_ENABLE_PULSE_CYC)) begin
                    d.pins.cmd = `DRPD_CMD_NOP;
                    d.pins.cke = 1'b1;
                    d.st = drpd_pkg::PD_EXIT;
                    load = 1'b1;
                    loadVal = q.slowExit ? 10'(`DRPD_PD_EXIT_DLL_DELAY_CYC - 1) : 10'(`DRPD_TXP_CYC - 1);
                    if (10'(`DRPD_MIN_CLOCK_ENABLE_PULSE_CYC - 1) > loadVal) begin
                        loadVal = 10'(`DRPD_MIN_CLOCK_ENABLE_PULSE_CYC - 1);
                    end
                end
            end
            drpd_pkg::PD_EXIT: begin
                if (waitZero) begin
                    d.st = drpd_pkg::IDLE;
                end
            end
            default: begin
                d.st = drpd_pkg::IDLE;
            end
        endcase
        if (userPass) begin
            d.pins.cmd = user.cmd;
            d.stat.cmdTaken = 1'b1;
        end
        // Debt rises each interval, falls per refresh; self-refresh pays its own
        // Entry prep counts as self-refresh; a tick in the entry cycle itself still adds debt after the entry check
        inc = tick && !urgent && q.st != drpd_pkg::SR_PREP && q.st != drpd_pkg::SR && q.st != drpd_pkg::SR_WAKE;
        d.debt = q.debt + $signed({4'h0, inc}) - $signed({4'h0, refGo});
        if (user.dramRst) begin
            d.st = drpd_pkg::IDLE;
            d.debt = `DRPD_DEBT_ZERO;
            d.pins.cmd = `DRPD_CMD_DES;
            d.pins.cke = 1'b0;
            d.pins.termination_control = 1'b0;
            d.pins.resetN = 1'b0;
            d.stat.cmdTaken = 1'b0;
            d.stat.refAck = 1'b0;
        end
        d.stat.debt = d.debt;
        d.stat.refUrgent = (d.debt >= `DRPD_DEBT_MAX);
        d.stat.inSelfRefresh = (d.st == drpd_pkg::SR) || (d.st == drpd_pkg::SR_WAKE);
        d.stat.inPowerDown = (d.st == drpd_pkg::PD_ENTRY) || (d.st == drpd_pkg::PD);
        d.stat.dllReady = (d.st == drpd_pkg::IDLE) || (d.st == drpd_pkg::REF_WAIT);
    end

    always_ff @(posedge clk or negedge rstLocalN) begin
        if (!rstLocalN) begin
            q <= '0;
            q.pins.cmd <= `DRPD_CMD_DES;
        end else begin
            q <= d;
        end
    end

    assign pins = q.pins;
    assign status = q.stat;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstLocalN);

    logic refNow, sreNow;
    assign refNow = (q.pins.cmd == `DRPD_CMD_REF) && q.pins.cke;
    assign sreNow = (q.pins.cmd == `DRPD_CMD_REF) && !q.pins.cke && (q.st == drpd_pkg::SR);

    sequence srxStart;
        $rose(q.pins.cke) && (q.st == drpd_pkg::SR_EXIT);
    endsequence
    sequence nopRun4;
        (q.pins.cmd == `DRPD_CMD_NOP) [*4];
    endsequence

    a_ref_after_idle: assert property (refNow |-> $past(prechOk))
        else $error("refresh issued before banks idle for precharge time");
    a_ref_nop_gap: assert property (refNow |=> (q.pins.cmd == `DRPD_CMD_NOP) [*3])
        else $error("command issued inside refresh cycle time");
    a_debt_range: assert property (q.debt <= `DRPD_DEBT_MAX && q.debt >= `DRPD_DEBT_MIN)
        else $error("refresh debt outside bounds");
    a_sre_no_debt: assert property (sreNow |-> q.debt <= `DRPD_DEBT_ZERO)
        else $error("self-refresh entered with postponed refreshes");
    a_sre_odt_off: assert property (sreNow |-> !$past(q.pins.termination_control) && !$past(q.pins.termination_control, 5))
        else $error("termination control not low before self-refresh entry");
    a_sr_cke_low: assert property (q.stat.inSelfRefresh |-> !q.pins.cke)
        else $error("clock enable high during self-refresh");
    a_srx_nop_run: assert property (srxStart |-> nopRun4)
        else $error("non-NO_OPERATION command inside self-refresh exit delay");
    a_xsdll_odt_off: assert property ((q.st == drpd_pkg::SR_EXIT || q.st == drpd_pkg::SR_DLL)
        |-> q.pins.cke && !q.pins.termination_control)
        else $error("clock enable low or termination on during DLL exit delay");
    a_sr_dll_cmd: assert property ((q.stat.cmdTaken && q.st == drpd_pkg::SR_DLL) |-> !$past(user.cmdNeedsDll))
        else $error("DLL command passed before DLL exit delay");
    a_pd_not_busy: assert property (($fell(q.pins.cke) && q.st == drpd_pkg::PD_ENTRY) |-> !$past(user.busyOp))
        else $error("power-down entered during busy operation");
    a_pd_entry_nop: assert property ((q.st == drpd_pkg::PD_ENTRY) |-> q.pins.cmd == `DRPD_CMD_NOP)
        else $error("command other than NO_OPERATION during power-down entry");
    a_slow_exit_odt: assert property ((q.st == drpd_pkg::PD_EXIT && q.slowExit) |-> !q.pins.termination_control)
        else $error("termination control raised before slow exit delay");
    a_cke_low_min: assert property (($fell(q.pins.cke) && q.pins.resetN) |-> (!q.pins.cke) [*2])
        else $error("clock enable low pulse too short");
endmodule // drpd_ctrl

/* File: src/drpd_map.svh */
// Constants of the refresh and power-down sequencer: command codes, limits, timing counts.
// Assumes a 25 MHz controller clock that is also the memory clock, so one cycle is one nCK.
// Behaviour
// - Refresh only after all banks precharged and idle
// - Only NO_OPERATION or deselect during refresh cycle time
// - At most eight refreshes postponed
// - At most eight refreshes pulled in
// - Postponed refreshes done before self-refresh entry (a tick in the entry cycle still adds one that is not paid)
// - Self-refresh entry is refresh with clock enable low
// - Banks idle and termination off before self-refresh
// - No DLL-needing command for 512 cycles after exit
// - Minimum stay, clock stop and restart margins
// - Exit with NO_OPERATION, only NOPs until exit delay
// - Clock enable high, termination off through DLL delay
// - No power-down during busy operations
// - NOPs through power-down entry delay
// - Keep bit chooses slow or fast exit
// - Clock enable pulse minimum, bounded power-down stay
`ifndef DRPD_MAP_SVH
`define DRPD_MAP_SVH

`define DRPD_CLK_PS 40000
`define DRPD_CYC_UP(ps) (((ps) + `DRPD_CLK_PS - 1) / `DRPD_CLK_PS)

// Command codes as {csN, rasN, casN, weN}
`define DRPD_CMD_NOP 4'h7
`define DRPD_CMD_DES 4'hF
`define DRPD_CMD_REF 4'h1

`define DRPD_DEBT_MAX 5'sh08
`define DRPD_DEBT_MIN 5'sh18
`define DRPD_DEBT_ZERO 5'sh00
`define DRPD_TMR_W 10

// Average interval rounds down so the schedule never runs late
`define DRPD_AVG_REFRESH_INTERVAL_PS 7800000
`define DRPD_AVG_REFRESH_INTERVAL_CYC (`DRPD_AVG_REFRESH_INTERVAL_PS / `DRPD_CLK_PS)
`define DRPD_REFRESH_CYCLE_TIME_PS 110000
`define DRPD_REFRESH_CYCLE_TIME_CYC `DRPD_CYC_UP(`DRPD_REFRESH_CYCLE_TIME_PS)
`define DRPD_TRP_PS 13750
`define DRPD_TRP_CYC `DRPD_CYC_UP(`DRPD_TRP_PS)
`define DRPD_TXS_PS 120000
`define DRPD_TXS_CYC `DRPD_CYC_UP(`DRPD_TXS_PS)
`define DRPD_SR_EXIT_DLL_DELAY_CYC 512
`define DRPD_MIN_CLOCK_ENABLE_PULSE_PS 5000
`define DRPD_MIN_CLOCK_ENABLE_PULSE_CYC `DRPD_CYC_UP(`DRPD_MIN_CLOCK_ENABLE_PULSE_PS)
`define DRPD_SR_ENTRY_CLOCK_HOLD_PS 10000
`define DRPD_SR_ENTRY_CLOCK_HOLD_CYC `DRPD_CYC_UP(`DRPD_SR_ENTRY_CLOCK_HOLD_PS)
`define DRPD_SR_EXIT_CLOCK_SETUP_PS 10000
`define DRPD_SR_EXIT_CLOCK_SETUP_CYC `DRPD_CYC_UP(`DRPD_SR_EXIT_CLOCK_SETUP_PS)
`define DRPD_TXP_PS 6000
`define DRPD_TXP_CYC `DRPD_CYC_UP(`DRPD_TXP_PS)
`define DRPD_PD_EXIT_DLL_DELAY_PS 24000
`define DRPD_PD_EXIT_DLL_DELAY_CYC `DRPD_CYC_UP(`DRPD_PD_EXIT_DLL_DELAY_PS)
`define DRPD_PD_ENTRY_CMD_DELAY_CYC 1
// Termination latency plus half a cycle, rounded up to whole cycles
`define DRPD_ODTL_CYC 4
`define DRPD_ODT_OFF_CYC (`DRPD_ODTL_CYC + 1)

`endif

/* File: src/drpd_pkg.sv */
// Types of the refresh and power-down sequencer.
// Constants live in drpd_map.svh; this package holds only types.
package drpd_pkg;

    typedef enum logic [3:0] {
        IDLE = 4'h0,
        REF_WAIT = 4'h1,
        SR_PREP = 4'h2,
        SR = 4'h3,
        SR_WAKE = 4'h4,
        SR_EXIT = 4'h5,
        SR_DLL = 4'h6,
        PD_ENTRY = 4'h7,
        PD = 4'h8,
        PD_EXIT = 4'h9
    } drpd_state_type;

    typedef struct packed {
        logic [3:0] cmd;
        logic cke;
        logic termination_control;
        logic resetN;
    } drpd_pins_type;

    typedef struct packed {
        logic cmdValid;
        logic [3:0] cmd;
        logic cmdNeedsDll;
        logic odtReq;
        logic refReq;
        logic srEnterReq;
        logic srExitReq;
        logic pdEnterReq;
        logic pdExitReq;
        logic banksIdle;
        logic busyOp;
        logic dllKeep;
        logic dramRst;
    } drpd_user_type;

    typedef struct packed {
        logic cmdTaken;
        logic refAck;
        logic refUrgent;
        logic inSelfRefresh;
        logic inPowerDown;
        logic clkStopOk;
        logic dllReady;
        logic signed [4:0] debt;
    } drpd_status_type;

    typedef struct packed {
        logic [9:0] cnt;
    } drpd_timer_state_type;

endpackage

/* File: src/drpd_timer.sv */
// Down counter with load; zero reads high once the loaded count has run out.
// Load and value come from logic on the same clock.
`timescale 1ns/1ps
module drpd_timer (
    input wire logic clk,
    input wire logic rstN,
    input wire logic load,
    input wire logic [9:0] loadVal,
    output logic zero
);
    drpd_pkg::drpd_timer_state_type q, d;

    always_comb begin
        d = q;
        if (load) begin
            d.cnt = loadVal;
        end else if (q.cnt != 10'h000) begin
            d.cnt = q.cnt - 10'h001;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign zero = (q.cnt == 10'h000);
endmodule // drpd_timer
